// File: hw/sdp_dither_shifter.sv
// stn frame-rate-control dither and panel data shifter
// assumes pixel, frame and line strobes come from logic on ref_clk
//
// Operation
// R1 - dither only for stn panel kinds
// R2 - level fifteen always lit, zero always dark
// R3 - levels fourteen to eight use patterns directly
// R4 - levels one to seven invert complementary pattern
// R5 - pattern sequence steps per frame, wraps
// R6 - position 4n+m selects pattern bit 3-m
// R7 - neighbour patterns change from frame to frame
// R8 - colour components each take own position
// R9 - components placed msb first on data lines
// R10 - dual scan halves behave like single scan
// R11 - one pixel or three components per step
// R12 - shifter packs stream into panel bus words
// R13 - panel kind selects tft, mono, colour
// R14 - tft allows single scan only
// R15 - stn widths four, eight, sixteen bits
// R16 - shade is four msbs of palette entry
// R17 - tft data passes through undithered
`timescale 1ns/100ps
`include "sdp_defines.svh"

module sdp_dither_shifter
  import sdp_pkg::*;
#(
  parameter int FRAME_CNT_W = 8
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic [`SDP_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output      logic [31:0]            reg_rdata,
  input  wire logic                   frame_start,
  input  wire logic                   line_start,
  input  wire logic                   pix_valid,
  input  wire logic                   pix_lower,
  input  wire logic [4:0]             pix_red,
  input  wire logic [4:0]             pix_green,
  input  wire logic [4:0]             pix_blue,
  input  wire logic                   pix_intensity,
  output      logic [23:0]            panel_data_bus,
  output      logic [1:0]             panel_data_valid
);

  if (FRAME_CNT_W < 1 || FRAME_CNT_W > 24) begin : g_bad_cnt
    $error("sdp_dither_shifter: FRAME_CNT_W must be 1 to 24");
  end

  localparam int PW = `SDP_PAT_BITS;
  localparam int NP = `SDP_NUM_PAT;
  localparam logic [2:0] PAT_LEN [NP] = '{
    `SDP_LEN_SIX_SEV, `SDP_LEN_FOUR_FIF, `SDP_LEN_THREE_QU,
    `SDP_LEN_FIVE_SEV, `SDP_LEN_TWO_THI, `SDP_LEN_THREE_FIF,
    `SDP_LEN_FOUR_SEV, `SDP_LEN_ONE_HALF};

  // ==========================================================
  // functions
  function automatic logic pat_hit(input logic [`SDP_ADDR_W-1:0] a);
    return (a >= `SDP_OFF_PAT_FIRST) && (a <= `SDP_OFF_PAT_LAST) &&
           (a[1:0] == 2'h0);
  endfunction
  function automatic logic [2:0] pat_idx(input logic [`SDP_ADDR_W-1:0] a);
    logic [`SDP_ADDR_W-1:0] d;
    d = a - `SDP_OFF_PAT_FIRST;
    return d[4:2];
  endfunction
  // lit decision of one component from its level and position
  function automatic logic lit_bit(input logic [3:0]  lvl,
                                   input logic [1:0]  m,
                                   input logic [31:0] nibs);
    sdp_pat_t   idx;
    logic       inv;
    logic [3:0] nib;
    inv = 1'b0;
    // R3 - direct pattern choice
    // R4 - inverted complementary choice
    case (lvl)
      4'hE: idx = pattern_six_sevenths;
      4'hD: idx = pattern_four_fifths;
      4'hC: idx = pattern_three_quarters;
      4'hB: idx = pattern_five_sevenths;
      4'hA: idx = pattern_two_thirds;
      4'h9: idx = pattern_three_fifths;
      4'h8: idx = pattern_four_sevenths;
      4'h7: begin idx = pattern_one_half;       inv = 1'b1; end
      4'h6: begin idx = pattern_four_sevenths;  inv = 1'b1; end
      4'h5: begin idx = pattern_three_fifths;   inv = 1'b1; end
      4'h4: begin idx = pattern_two_thirds;     inv = 1'b1; end
      4'h3: begin idx = pattern_three_quarters; inv = 1'b1; end
      4'h2: begin idx = pattern_four_fifths;    inv = 1'b1; end
      4'h1: begin idx = pattern_six_sevenths;   inv = 1'b1; end
      default: idx = pattern_one_half;
    endcase
    nib = nibs[{idx, 2'h0} +: 4];
    // R6 - position m picks bit 3-m
    // R2 - extremes bypass the lookup
    return (lvl == `SDP_LEVEL_FULL) ||
           ((lvl != `SDP_LEVEL_DARK) && (nib[`SDP_BIT_TOP - m] ^ inv));
  endfunction

  // ==========================================================
  // register file
  logic [31:0]            ctrl_r, ctrl_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic [NP*PW-1:0]       pat_words;
  logic                   pat_wr;
  logic [FRAME_CNT_W-1:0] frame_cnt_r, frame_cnt_nxt;
  sdp_kind_t              kind;
  sdp_width_t             width;
  logic                   dual;
  logic                   cfg_err;

  assign pat_wr = reg_wr && pat_hit(reg_addr);
  sdp_pattern_mem #(
    .NUM   (NP),
    .WIDTH (PW)
  ) u_pat (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (pat_wr),
    .wr_idx  (pat_idx(reg_addr)),
    .wr_data (reg_wdata[PW-1:0]),
    .words   (pat_words)
  );
  // R13 - panel kind from control
  assign kind  = sdp_kind_t'(ctrl_r[`SDP_CTRL_KIND_MSB:`SDP_CTRL_KIND_LSB]);
  assign width = sdp_width_t'(ctrl_r[`SDP_CTRL_WIDTH_MSB:`SDP_CTRL_WIDTH_LSB]);
  assign dual  = ctrl_r[`SDP_CTRL_SCAN_BIT];
  // R14 - tft dual scan refused
  // R15 - stn width and scan pairing
  always_comb begin
    case (kind)
      sdp_kind_tft:    cfg_err = dual;
      sdp_kind_mono,
      sdp_kind_colour: cfg_err = (width == sdp_width_4 && dual) ||
                                 (width == sdp_width_16 && !dual) ||
                                 (width != sdp_width_4 &&
                                  width != sdp_width_8 &&
                                  width != sdp_width_16);
      default:         cfg_err = 1'b1;
    endcase
  end

  always_comb begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr && reg_addr == `SDP_OFF_CTRL) begin
      ctrl_nxt = 32'h0000_0000;
      ctrl_nxt[`SDP_CTRL_WIDTH_MSB:`SDP_CTRL_KIND_LSB] =
        reg_wdata[`SDP_CTRL_WIDTH_MSB:`SDP_CTRL_KIND_LSB];
    end
    if (reg_rd) begin
      if (reg_addr == `SDP_OFF_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (reg_addr == `SDP_OFF_STAT) begin
        rdata_nxt[`SDP_STAT_ERR_BIT] = cfg_err;
        rdata_nxt[`SDP_STAT_FRAME_LSB +: FRAME_CNT_W] = frame_cnt_r;
      end else if (pat_hit(reg_addr)) begin
        rdata_nxt[PW-1:0] = pat_words[{pat_idx(reg_addr), 5'h00} -
                                      {pat_idx(reg_addr), 2'h0} +: PW];
      end
    end
  end

  // ==========================================================
  // frame sequencing
  logic [NP-1:0][`SDP_PHASE_W-1:0] phase_r, phase_nxt;
  logic [31:0]                     cur_nibs;
  // R5 - step each sequence, wrap at its length
  // R7 - neighbours see a new pattern every frame
  always_comb begin
    phase_nxt     = phase_r;
    frame_cnt_nxt = frame_cnt_r;
    if (frame_start) begin
      frame_cnt_nxt = frame_cnt_r + 1'b1;
      for (int i = 0; i < NP; i++) begin
        if (phase_r[i] >= PAT_LEN[i] - 3'h1) begin
          phase_nxt[i] = '0;
        end else begin
          phase_nxt[i] = phase_r[i] + 3'h1;
        end
      end
    end
  end

  // first nibble of a sequence sits in the top bits of the word
  always_comb begin
    cur_nibs = 32'h0000_0000;
    for (int i = 0; i < NP; i++) begin
      cur_nibs[i*4 +: 4] =
        pat_words[i*PW + PW - 4 - 4*int'(phase_r[i]) +: 4];
    end
  end

  // ==========================================================
  // dither and shifter
  logic [1:0][1:0]  pos_r, pos_nxt;
  logic [1:0][15:0] acc_r, acc_nxt;
  logic [1:0][4:0]  cnt_r, cnt_nxt;
  logic [23:0]      bus_r, bus_nxt;
  logic [1:0]       valid_r, valid_nxt;
  logic [3:0]       shade [3];
  logic [2:0]       lit_c;
  logic             half;
  logic [1:0]       p;
  logic [15:0]      acc_a;
  logic [4:0]       cnt_a, hw, nbits, base;
  logic [7:0]       word, mask;
  logic             colour;
  // R16 - shade from the four msbs
  assign shade[0] = pix_red[4:1];
  assign shade[1] = pix_green[4:1];
  assign shade[2] = pix_blue[4:1];
  assign colour   = (kind == sdp_kind_colour);
  // R10 - each half owns its own position and shifter
  assign half     = dual && pix_lower;
  assign p        = pos_r[half];
  // R8 - components take consecutive positions
  assign lit_c[2] = lit_bit(shade[0], p, cur_nibs);
  assign lit_c[1] = lit_bit(shade[1], 2'(p + 2'h1), cur_nibs);
  assign lit_c[0] = lit_bit(shade[2], 2'(p + 2'h2), cur_nibs);
  assign hw       = (width == sdp_width_8 && !dual) ||
                    width == sdp_width_16 ? `SDP_HW_WIDE : `SDP_HW_NARROW;
  // R11 - one pixel or three components per step
  assign nbits    = colour ? `SDP_BITS_COLOUR : `SDP_BITS_MONO;
  assign base     = (dual && !half) ? hw : 5'h00;
  always_comb begin
    pos_nxt   = pos_r;
    acc_nxt   = acc_r;
    cnt_nxt   = cnt_r;
    bus_nxt   = bus_r;
    valid_nxt = 2'b00;
    acc_a     = acc_r[half] |
                ({(colour ? lit_c : {lit_c[2], 2'b00}), 13'h0000} >>
                 cnt_r[half]);
    cnt_a     = cnt_r[half] + nbits;
    word      = (hw == `SDP_HW_WIDE) ? acc_a[15:8] : {4'h0, acc_a[15:12]};
    mask      = (hw == `SDP_HW_WIDE) ? 8'hFF : 8'h0F;
    if (line_start) begin
      pos_nxt = '0;
      acc_nxt = '0;
      cnt_nxt = '0;
    end else if (pix_valid && !cfg_err) begin
      if (kind == sdp_kind_tft) begin
        // R17 - tft bypasses the dither
        bus_nxt   = {pix_blue, pix_intensity, 2'b00,
                     pix_green, pix_intensity, 2'b00,
                     pix_red, pix_intensity, 2'b00};
        valid_nxt = 2'b01;
      end else begin
        // R1 - stn kinds only reach the dither
        pos_nxt[half] = p + (colour ? `SDP_STEP_COLOUR : `SDP_STEP_MONO);
        // R12 - pack into hw-bit words placed at base
        // R9 - first component lands on the top line
        if (cnt_a >= hw) begin
          acc_nxt[half]   = acc_a << hw;
          cnt_nxt[half]   = cnt_a - hw;
          bus_nxt         = (bus_r & ~({16'h0000, mask} << base)) |
                            ({16'h0000, word} << base);
          valid_nxt[half] = 1'b1;
        end else begin
          acc_nxt[half] = acc_a;
          cnt_nxt[half] = cnt_a;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r      <= `SDP_CTRL_RESET;
      rdata_r     <= '0;
      frame_cnt_r <= '0;
      phase_r     <= '0;
      pos_r       <= '0;
      acc_r       <= '0;
      cnt_r       <= '0;
      bus_r       <= '0;
      valid_r     <= '0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      rdata_r     <= rdata_nxt;
      frame_cnt_r <= frame_cnt_nxt;
      phase_r     <= phase_nxt;
      pos_r       <= pos_nxt;
      acc_r       <= acc_nxt;
      cnt_r       <= cnt_nxt;
      bus_r       <= bus_nxt;
      valid_r     <= valid_nxt;
    end
  end
  assign reg_rdata        = rdata_r;
  assign panel_data_bus   = bus_r;
  assign panel_data_valid = valid_r;

  // ==========================================================
  // checks
  chk_full_lit: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
    shade[0] == `SDP_LEVEL_FULL |-> lit_c[2])
    else $error("level fifteen not lit");
  chk_dark_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
    shade[1] == `SDP_LEVEL_DARK |-> !lit_c[1])
    else $error("level zero lit");
  chk_inv_pair: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
    shade[0] == 4'h1 |-> lit_c[2] == !cur_nibs[`SDP_BIT_TOP - p])
    else $error("level one not inverse of fourteen");
  chk_half_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
    frame_start && phase_r[7] == 3'h1 |=> phase_r[7] == 3'h0)
    else $error("one half sequence did not wrap");
  chk_sev_step: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
    frame_start && phase_r[0] < 3'h6
    |=> phase_r[0] == $past(phase_r[0]) + 3'h1)
    else $error("six sevenths sequence did not step");
  chk_col_pos: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
    pix_valid && !line_start && !cfg_err && colour && !dual
    |=> pos_r[0] == 2'($past(pos_r[0]) + 2'h3))
    else $error("colour position did not advance by three");
  chk_tft_pass: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
    pix_valid && !line_start && !cfg_err && kind == sdp_kind_tft
    |=> panel_data_valid == 2'b01 &&
        panel_data_bus[7:3] == $past(pix_red) &&
        panel_data_bus[23:19] == $past(pix_blue))
    else $error("tft data not passed through");
  chk_tft_scan: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
    kind == sdp_kind_tft && dual |=> panel_data_valid == 2'b00)
    else $error("tft dual scan produced data");
  chk_mono_word: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
    line_start ##1 (pix_valid && !line_start && kind == sdp_kind_mono &&
                    width == sdp_width_4 && !dual && !cfg_err) [*4]
    |=> panel_data_valid[0])
    else $error("four mono pixels did not make a word");

endmodule

// File: hw/sdp_defines.svh
// constants for the stn dither and pixel shifter
// assumes it is included by bare name from each design file that uses its macros
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH

// ==========================================================
// register map (byte offsets)
`define SDP_ADDR_W          6
`define SDP_OFF_CTRL        6'h00
`define SDP_OFF_STAT        6'h04
`define SDP_OFF_PAT_FIRST   6'h10
`define SDP_OFF_PAT_LAST    6'h2C
`define SDP_CTRL_RESET      32'h0000_0000

// ==========================================================
// control fields
`define SDP_CTRL_KIND_MSB   1
`define SDP_CTRL_KIND_LSB   0
`define SDP_CTRL_SCAN_BIT   2
`define SDP_CTRL_WIDTH_MSB  4
`define SDP_CTRL_WIDTH_LSB  3
`define SDP_STAT_ERR_BIT    0
`define SDP_STAT_FRAME_LSB  8

// ==========================================================
// pattern storage
`define SDP_NUM_PAT         8
`define SDP_PAT_BITS        28
`define SDP_PHASE_W         3
`define SDP_LEN_SIX_SEV     3'h7
`define SDP_LEN_FOUR_FIF    3'h5
`define SDP_LEN_THREE_QU    3'h4
`define SDP_LEN_FIVE_SEV    3'h7
`define SDP_LEN_TWO_THI     3'h3
`define SDP_LEN_THREE_FIF   3'h5
`define SDP_LEN_FOUR_SEV    3'h7
`define SDP_LEN_ONE_HALF    3'h2

// ==========================================================
// shifter geometry
`define SDP_HW_NARROW       5'h04
`define SDP_HW_WIDE         5'h08
`define SDP_BITS_MONO       5'h01
`define SDP_BITS_COLOUR     5'h03
`define SDP_STEP_MONO       2'h1
`define SDP_STEP_COLOUR     2'h3
`define SDP_BIT_TOP         2'h3
`define SDP_LEVEL_FULL      4'hF
`define SDP_LEVEL_DARK      4'h0

`endif

// File: hw/sdp_pkg.sv
// types shared by the stn dither and pixel shifter
// assumes the defines header is compiled with it
package sdp_pkg;

  typedef enum logic [1:0] {
    sdp_kind_tft    = 2'h0,
    sdp_kind_mono   = 2'h1,
    sdp_kind_colour = 2'h2
  } sdp_kind_t;

  typedef enum logic [1:0] {
    sdp_width_4  = 2'h0,
    sdp_width_8  = 2'h1,
    sdp_width_16 = 2'h2
  } sdp_width_t;

  typedef enum logic [2:0] {
    pattern_six_sevenths   = 3'h0,
    pattern_four_fifths    = 3'h1,
    pattern_three_quarters = 3'h2,
    pattern_five_sevenths  = 3'h3,
    pattern_two_thirds     = 3'h4,
    pattern_three_fifths   = 3'h5,
    pattern_four_sevenths  = 3'h6,
    pattern_one_half       = 3'h7
  } sdp_pat_t;

endpackage

// File: hw/sdp_pattern_mem.sv
// dither pattern word store, one write port, all words visible
// assumes writes come from the register decode of the top module
`timescale 1ns/100ps
`include "sdp_defines.svh"

module sdp_pattern_mem
  import sdp_pkg::*;
#(
  parameter int NUM   = `SDP_NUM_PAT,
  parameter int WIDTH = `SDP_PAT_BITS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic                   wr_en,
  input  wire logic [2:0]             wr_idx,
  input  wire logic [WIDTH-1:0]       wr_data,
  output      logic [NUM*WIDTH-1:0]   words
);

  if (NUM < 1 || NUM > 8) begin : g_bad_num
    $error("sdp_pattern_mem: NUM must be 1 to 8");
  end

  logic [NUM-1:0][WIDTH-1:0] mem_r;
  logic [NUM-1:0][WIDTH-1:0] mem_nxt;

  always_comb begin
    mem_nxt = mem_r;
    if (wr_en) begin
      mem_nxt[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // words come straight from the storage flops
  assign words = mem_r;

endmodule

// File: hw/sdp_dither_shifter_fix_note.sv
// spare design file: holds no logic of its own
// assumes the shifter and its pattern store sit in their own files

// File: test/sdp_panel_model.sv
// panel driver input model: latches every word the shifter hands out
// assumes valid pulses are one ref_clk cycle wide, one half at a time
`timescale 1ns/100ps

module sdp_panel_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [23:0] panel_data_bus,
  input  wire logic [1:0]  panel_data_valid,
  output      logic [23:0] last_word,
  output      logic [1:0]  last_half,
  output      logic [15:0] word_cnt
);
  // ==========================================================
  // word capture
  // the panel clocks data only on a valid pulse, never between
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_word <= 24'h000000;
      last_half <= 2'h0;
      word_cnt  <= 16'h0000;
    end else if (panel_data_valid != 2'h0) begin
      last_word <= panel_data_bus;
      last_half <= panel_data_valid;
      word_cnt  <= word_cnt + 16'h0001;
    end
  end
endmodule

// File: test/tb_sdp_dither_shifter.sv
// self-checking bench for the stn dither and pixel shifter
// assumes the design files and the panel model compile before it
`timescale 1ns/100ps
`include "sdp_defines.svh"

module tb_sdp_dither_shifter
  import sdp_pkg::*;
;
  localparam logic [31:0] PAT_3_5 = 32'h0A5A_5F00;
  localparam logic [31:0] PAT_2_3 = 32'h0DB6_0000;

  logic                   ref_clk;
  logic                   rst_b;
  logic [`SDP_ADDR_W-1:0] reg_addr;
  logic [31:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [31:0]            reg_rdata;
  logic                   frame_start;
  logic                   line_start;
  logic                   pix_valid;
  logic                   pix_lower;
  logic [4:0]             pix_red;
  logic [4:0]             pix_green;
  logic [4:0]             pix_blue;
  logic                   pix_intensity;
  logic [23:0]            panel_data_bus;
  logic [1:0]             panel_data_valid;
  logic [23:0]            last_word;
  logic [1:0]             last_half;
  logic [15:0]            word_cnt;
  int                     miscompares;
  int                     samples_checked;
  int                     frame_no;

  // ==========================================================
  // instances
  sdp_dither_shifter i_sdp_dither_shifter (
    .ref_clk          (ref_clk),
    .rst_b            (rst_b),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .frame_start      (frame_start),
    .line_start       (line_start),
    .pix_valid        (pix_valid),
    .pix_lower        (pix_lower),
    .pix_red          (pix_red),
    .pix_green        (pix_green),
    .pix_blue         (pix_blue),
    .pix_intensity    (pix_intensity),
    .panel_data_bus   (panel_data_bus),
    .panel_data_valid (panel_data_valid)
  );

  sdp_panel_model i_sdp_panel_model (
    .ref_clk          (ref_clk),
    .rst_b            (rst_b),
    .panel_data_bus   (panel_data_bus),
    .panel_data_valid (panel_data_valid),
    .last_word        (last_word),
    .last_half        (last_half),
    .word_cnt         (word_cnt)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // shared tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [`SDP_ADDR_W-1:0] a,
                           input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [`SDP_ADDR_W-1:0] a,
                          output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulse(input logic frame);
    @(posedge ref_clk);
    frame_start <= frame;
    line_start  <= !frame;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    line_start  <= 1'b0;
    if (frame) begin
      frame_no++;
    end
  endtask

  // leaves pix_valid high so steps run back to back
  task automatic pix(input logic [3:0] r, input logic [3:0] g,
                     input logic [3:0] b, input logic lower);
    @(posedge ref_clk);
    pix_valid <= 1'b1;
    line_start <= 1'b0;
    pix_lower <= lower;
    pix_red   <= {r, 1'b0};
    pix_green <= {g, 1'b0};
    pix_blue  <= {b, 1'b0};
  endtask

  task automatic pix_end();
    @(posedge ref_clk);
    pix_valid <= 1'b0;
  endtask

  task automatic expect_word(input logic [15:0] n0, input logic [1:0] half,
                             input logic [23:0] mask,
                             input logic [23:0] exp);
    int i;
    for (i = 0; i < 12 && word_cnt == n0; i++) begin
      @(posedge ref_clk);
    end
    if (word_cnt == n0) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, n0, n0 + 1);
      test_done();
    end else begin
      check({30'h0, last_half}, {30'h0, half});
      check({8'h0, last_word & mask}, {8'h0, exp});
    end
  endtask

  function automatic logic [3:0] nib(input logic [31:0] w, input int len);
    return w[27 - 4 * (frame_no % len) -: 4];
  endfunction

  // ==========================================================
  // scenarios
  task automatic test_regs();
    logic [31:0] d;
    reg_read(`SDP_OFF_CTRL, d);
    check(d, `SDP_CTRL_RESET);
    reg_read(6'h3C, d);
    check(d, 32'h0000_0000);
    reg_write(`SDP_OFF_PAT_FIRST + 6'h14, PAT_3_5);
    reg_write(`SDP_OFF_PAT_FIRST + 6'h10, PAT_2_3);
    reg_read(`SDP_OFF_PAT_FIRST + 6'h14, d);
    check(d, PAT_3_5);
    $display("test regs done");
  endtask

  task automatic test_mono();
    logic [15:0] n0;
    logic [31:0] d;
    logic [3:0]  p;
    int          f;
    reg_write(`SDP_OFF_CTRL, {27'h0, sdp_width_4, 1'b0, sdp_kind_mono});
    // six frames on a five-long sequence shows the wrap
    for (f = 0; f < 6; f++) begin
      // line start directly before the first pixel, no idle gap
      n0 = word_cnt;
      @(posedge ref_clk);
      line_start <= 1'b1;
      repeat (4) pix(4'h9, 4'h0, 4'h0, 1'b0);
      pix_end();
      expect_word(n0, 2'h1, 24'h00000F, {20'h0, nib(PAT_3_5, 5)});
      pulse(1'b1);
    end
    pulse(1'b0);
    n0 = word_cnt;
    pix(4'hF, 4'h0, 4'h0, 1'b0);
    pix(4'h1, 4'h0, 4'h0, 1'b0);
    pix(4'h6, 4'h0, 4'h0, 1'b0);
    pix(4'h9, 4'h0, 4'h0, 1'b0);
    pix_end();
    p = nib(PAT_3_5, 5);
    expect_word(n0, 2'h1, 24'h00000F, {20'h0, 3'b111, p[0]});
    reg_read(`SDP_OFF_STAT, d);
    check(d & 32'h0000_FF01, {16'h0, frame_no[7:0], 8'h00});
    $display("test mono done");
  endtask

  task automatic test_colour();
    logic [15:0] n0;
    logic [3:0]  p;
    logic        w8;
    int          i;
    for (i = 0; i < 4; i++) begin
      w8 = i[1];
      reg_write(`SDP_OFF_CTRL, {27'h0, w8 ? sdp_width_8 : sdp_width_4,
                                1'b0, sdp_kind_colour});
      pulse(1'b0);
      n0 = word_cnt;
      repeat (w8 ? 3 : 2) pix(4'hA, 4'hA, 4'hA, 1'b0);
      pix_end();
      p = nib(PAT_2_3, 3);
      expect_word(n0, 2'h1, w8 ? 24'hFF : 24'h0F,
                  w8 ? {16'h0, p, p} : {20'h0, p});
      pulse(1'b1);
    end
    $display("test colour done");
  endtask

  task automatic test_tft_err();
    logic [15:0] n0;
    logic [31:0] d;
    reg_write(`SDP_OFF_CTRL, 32'h0000_0000);
    n0 = word_cnt;
    @(posedge ref_clk);
    pix_valid     <= 1'b1;
    pix_red       <= 5'h15;
    pix_green     <= 5'h0A;
    pix_blue      <= 5'h1F;
    pix_intensity <= 1'b1;
    pix_end();
    expect_word(n0, 2'h1, 24'hFFFFFF, {5'h1F, 3'h4, 5'h0A, 3'h4,
                                       5'h15, 3'h4});
    reg_write(`SDP_OFF_CTRL, {27'h0, sdp_width_4, 1'b1, sdp_kind_tft});
    reg_read(`SDP_OFF_STAT, d);
    check(d & 32'h1, 32'h1);
    n0 = word_cnt;
    repeat (4) pix(4'hF, 4'hF, 4'hF, 1'b0);
    pix_end();
    repeat (4) @(posedge ref_clk);
    check({16'h0, word_cnt}, {16'h0, n0});
    $display("test tft and refusal done");
  endtask

  task automatic test_dual();
    logic [15:0] n0;
    logic [31:0] d;
    reg_write(`SDP_OFF_CTRL, {27'h0, sdp_width_8, 1'b1, sdp_kind_mono});
    pulse(1'b0);
    n0 = word_cnt;
    repeat (4) pix(4'hF, 4'h0, 4'h0, 1'b0);
    pix_end();
    expect_word(n0, 2'h1, 24'h0000F0, 24'h0000F0);
    n0 = word_cnt;
    repeat (4) pix(4'h0, 4'h0, 4'h0, 1'b1);
    pix_end();
    expect_word(n0, 2'h2, 24'h0000FF, 24'h0000F0);
    reg_write(`SDP_OFF_CTRL, {27'h0, sdp_width_16, 1'b1, sdp_kind_mono});
    pulse(1'b0);
    n0 = word_cnt;
    repeat (8) pix(4'hF, 4'h0, 4'h0, 1'b0);
    pix_end();
    expect_word(n0, 2'h1, 24'h00FF00, 24'h00FF00);
    reg_write(`SDP_OFF_CTRL, {27'h0, sdp_width_4, 1'b1, sdp_kind_mono});
    reg_read(`SDP_OFF_STAT, d);
    check(d & 32'h1, 32'h1);
    $display("test dual scan done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_b           = 1'b0;
    reg_addr        = '0;
    reg_wdata       = 32'h0000_0000;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    frame_start     = 1'b0;
    line_start      = 1'b0;
    pix_valid       = 1'b0;
    pix_lower       = 1'b0;
    pix_red         = 5'h00;
    pix_green       = 5'h00;
    pix_blue        = 5'h00;
    pix_intensity   = 1'b0;
    miscompares     = 0;
    samples_checked = 0;
    frame_no        = 0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    test_regs();
    test_mono();
    test_colour();
    test_tft_err();
    test_dual();
    test_done();
  end
endmodule
